// >>> port_crossbar_map.svh
// Overview of operation
// - Route bits 7..4 enable comparator1 async/sync and comparator0 async/sync outputs.
// - Route register A bit 3 places the system clock on a pin.
// - Route register A bit 2 places the first two-wire bus on pins.
// - Route register A bit 1 places SPI on three or four pins.
// - Route register A bit 0 puts UART A transmit/receive on P0.4/P0.5.
// - Route register B bit 7 disables all weak pullups when set.
// - Route register B bits 5 and 4 route timer1 and timer0 inputs.
// - Route register B bit 3 routes the counter external input.
// - Compare field picks none, one to four outputs; 11x reserved.
// - Route register C bit 1 routes second two-wire bus; bits 7..2 written zero.
// - Route register C bit 0 routes UART B transmit and receive.
// - Unclaimed pins are GPIO; ports 3..0 bit access, port 4 byte only.
// - Port data write stores value in a latch that holds the pin level.
// - Plain port reads return pin levels, even for crossbar-owned pins.
// - Read-modify-write operations on ports read the latch, not the pins.
// - With crossbar disabled every pin of ports 0..3 stays a plain port input.
// - Ports 0..3 drivers off while crossbar disabled; port 4 always GPIO.
`ifndef PORT_CROSSBAR_MAP_SVH
`define PORT_CROSSBAR_MAP_SVH

`define ADDR_ROUTE_A      8'hE1
`define ADDR_ROUTE_B      8'hE2
`define ADDR_ROUTE_C      8'hE3
`define ADDR_PORT0        8'h80
`define ADDR_PORT1        8'h90
`define ADDR_PORT2        8'hA0
`define ADDR_PORT3        8'hB0
`define ADDR_PORT4        8'hC7

`define ROUTE_RESET       8'h00
`define LATCH_RESET       8'hFF
`define READ_IDLE         8'h00
`define ROUTE_C_MASK      8'h03

`define A_CMP1_ASYNC      7
`define A_CMP1_SYNC       6
`define A_CMP0_ASYNC      5
`define A_CMP0_SYNC       4
`define A_SYSTEM_CLOCK_SIGNAL          3
`define A_TWOWIRE         2
`define A_SPI             1
`define A_UART            0
`define B_PULLUP_DIS      7
`define B_XBAR_EN         6
`define B_TIMER1          5
`define B_TIMER0          4
`define B_COUNT_IN        3
`define B_CMP_SEL_HI      2
`define B_CMP_SEL_LO      0
`define C_TWOWIRE         1
`define C_UART            0

`define UART_A_TX_PIN     4
`define UART_A_RX_PIN     5
`define CMP_OUTS_MAX      4

`endif

// >>> port_crossbar_pkg.sv
package port_crossbar_pkg;

  // Peripheral signal slots, in crossbar priority order
  typedef enum logic [4:0] {
    SIG_UART_A_TX  = 5'b00000,
    SIG_UART_A_RX  = 5'b00001,
    SIG_SPI_SCK    = 5'b00010,
    SIG_SPI_MISO   = 5'b00011,
    SIG_SPI_MOSI   = 5'b00100,
    SIG_SPI_NSS    = 5'b00101,
    SIG_TWA_SDA    = 5'b00110,
    SIG_TWA_SCL    = 5'b00111,
    SIG_CMP0_SYNC  = 5'b01000,
    SIG_CMP0_ASYNC = 5'b01001,
    SIG_CMP1_SYNC  = 5'b01010,
    SIG_CMP1_ASYNC = 5'b01011,
    SIG_SYSTEM_CLOCK_SIGNAL     = 5'b01100,
    SIG_COMPARE_OUTPUT_FIRST       = 5'b01101,
    SIG_CEX1       = 5'b01110,
    SIG_CEX2       = 5'b01111,
    SIG_CEX3       = 5'b10000,
    SIG_COUNT_IN   = 5'b10001,
    SIG_TIMER0     = 5'b10010,
    SIG_TIMER1     = 5'b10011,
    SIG_TWB_SDA    = 5'b10100,
    SIG_TWB_SCL    = 5'b10101,
    SIG_UART_B_TX  = 5'b10110,
    SIG_UART_B_RX  = 5'b10111
  } sig_slot_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       rmw;
    logic       bit_op;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage

// >>> port_crossbar_routing.sv
`timescale 1ns/10ps
`include "port_crossbar_map.svh"

module port_crossbar_routing
  import port_crossbar_pkg::*;
#(
  parameter int NSIG      = 24,
  parameter int XBAR_PINS = 32,
  parameter int ALL_PINS  = 40
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire sfr_req_t             sfr_req,
  input  wire logic                 spi_four_wire,
  input  wire logic [XBAR_PINS-1:0] skip_mask,
  input  wire logic [NSIG-1:0]      per_out,
  input  wire logic [NSIG-1:0]      per_drive,
  input  wire logic [ALL_PINS-1:0]  pin_in,
  output logic [7:0]                sfr_rdata,
  output logic [NSIG-1:0]           per_in,
  output logic [ALL_PINS-1:0]       pin_out,
  output logic [ALL_PINS-1:0]       pin_oe_n,
  output logic [ALL_PINS-1:0]       pullup_en
);

  logic [7:0]          route_a_reg;
  logic [7:0]          route_b_reg;
  logic [7:0]          route_c_reg;
  logic [ALL_PINS-1:0] latch_reg;
  logic [ALL_PINS-1:0] latch_next;
  logic [7:0]          rdata_next;
  logic [NSIG-1:0]     req_vec;
  logic [XBAR_PINS-1:0] pin_owned;
  logic [4:0]          pin_slot [XBAR_PINS];
  logic [NSIG-1:0]     per_in_next;
  logic [ALL_PINS-1:0] out_next;
  logic [ALL_PINS-1:0] oe_n_next;
  logic [ALL_PINS-1:0] pull_next;
  logic                xbar_en;
  logic [2:0]          cmp_sel;
  logic                port_hit;
  logic [2:0]          port_idx;
  logic [2:0]          cmp_count;

  assign xbar_en = route_b_reg[`B_XBAR_EN];
  assign cmp_sel = route_b_reg[`B_CMP_SEL_HI:`B_CMP_SEL_LO];

  // Port decode for data registers
  always_comb begin
    port_hit = 1'b1;
    port_idx = 3'd0;
    unique case (sfr_req.addr)
      `ADDR_PORT0: port_idx = 3'd0;
      `ADDR_PORT1: port_idx = 3'd1;
      `ADDR_PORT2: port_idx = 3'd2;
      `ADDR_PORT3: port_idx = 3'd3;
      `ADDR_PORT4: port_idx = 3'd4;
      default:     port_hit = 1'b0;
    endcase
  end

  // Routing registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      route_a_reg <= `ROUTE_RESET;
      route_b_reg <= `ROUTE_RESET;
      route_c_reg <= `ROUTE_RESET;
    end else if (sfr_req.wr && !sfr_req.bit_op) begin
      unique case (sfr_req.addr)
        `ADDR_ROUTE_A: route_a_reg <= sfr_req.wdata;
        `ADDR_ROUTE_B: route_b_reg <= sfr_req.wdata;
        // Reserved bits not stored, so they always read back zero
        `ADDR_ROUTE_C: route_c_reg <= sfr_req.wdata & `ROUTE_C_MASK;
        default: ;
      endcase
    end
  end

  // Port output latches
  always_comb begin
    latch_next = latch_reg;
    if (sfr_req.wr && port_hit) begin
      if (!sfr_req.bit_op) begin
        latch_next[port_idx*8 +: 8] = sfr_req.wdata;
      end else if (port_idx != 3'd4) begin
        // Port 4 has no bit access; a bit write there is dropped
        latch_next[{port_idx, sfr_req.bit_sel}] = sfr_req.wdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_reg <= {(ALL_PINS/8){`LATCH_RESET}};
    end else begin
      latch_reg <= latch_next;
    end
  end

  // Read path, answered one cycle after the request
  always_comb begin
    rdata_next = `READ_IDLE;
    if (sfr_req.rd) begin
      if (port_hit) begin
        if (sfr_req.rmw) begin
          rdata_next = latch_reg[port_idx*8 +: 8];
        end else begin
          rdata_next = pin_in[port_idx*8 +: 8];
        end
      end else begin
        unique case (sfr_req.addr)
          `ADDR_ROUTE_A: rdata_next = route_a_reg;
          `ADDR_ROUTE_B: rdata_next = route_b_reg;
          `ADDR_ROUTE_C: rdata_next = route_c_reg;
          default:       rdata_next = `READ_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata <= `READ_IDLE;
    end else begin
      sfr_rdata <= rdata_next;
    end
  end

  // Compare output count; 11x is reserved and routes nothing
  always_comb begin
    unique case (cmp_sel)
      3'b000:  cmp_count = 3'd0;
      3'b001:  cmp_count = 3'd1;
      3'b010:  cmp_count = 3'd2;
      3'b011:  cmp_count = 3'd3;
      3'b100:  cmp_count = 3'd4;
      3'b101:  cmp_count = 3'd4;
      default: cmp_count = 3'd0;
    endcase
  end

  // Signals asking for a pin
  always_comb begin
    req_vec                 = '0;
    req_vec[SIG_UART_A_TX]  = route_a_reg[`A_UART];
    req_vec[SIG_UART_A_RX]  = route_a_reg[`A_UART];
    req_vec[SIG_SPI_SCK]    = route_a_reg[`A_SPI];
    req_vec[SIG_SPI_MISO]   = route_a_reg[`A_SPI];
    req_vec[SIG_SPI_MOSI]   = route_a_reg[`A_SPI];
    req_vec[SIG_SPI_NSS]    = route_a_reg[`A_SPI] && spi_four_wire;
    req_vec[SIG_TWA_SDA]    = route_a_reg[`A_TWOWIRE];
    req_vec[SIG_TWA_SCL]    = route_a_reg[`A_TWOWIRE];
    req_vec[SIG_CMP0_SYNC]  = route_a_reg[`A_CMP0_SYNC];
    req_vec[SIG_CMP0_ASYNC] = route_a_reg[`A_CMP0_ASYNC];
    req_vec[SIG_CMP1_SYNC]  = route_a_reg[`A_CMP1_SYNC];
    req_vec[SIG_CMP1_ASYNC] = route_a_reg[`A_CMP1_ASYNC];
    req_vec[SIG_SYSTEM_CLOCK_SIGNAL]     = route_a_reg[`A_SYSTEM_CLOCK_SIGNAL];
    for (int k = 0; k < `CMP_OUTS_MAX; k++) begin
      req_vec[int'(SIG_COMPARE_OUTPUT_FIRST) + k] = (3'(k) < cmp_count);
    end
    req_vec[SIG_COUNT_IN]   = route_b_reg[`B_COUNT_IN];
    req_vec[SIG_TIMER0]     = route_b_reg[`B_TIMER0];
    req_vec[SIG_TIMER1]     = route_b_reg[`B_TIMER1];
    req_vec[SIG_TWB_SDA]    = route_c_reg[`C_TWOWIRE];
    req_vec[SIG_TWB_SCL]    = route_c_reg[`C_TWOWIRE];
    req_vec[SIG_UART_B_TX]  = route_c_reg[`C_UART];
    req_vec[SIG_UART_B_RX]  = route_c_reg[`C_UART];
  end

  // Priority decoder: chained search, long but purely combinational
  always_comb begin
    logic [NSIG-1:0] remaining;
    logic            found;
    logic [4:0]      pick;
    remaining = req_vec;
    found     = 1'b0;
    pick      = 5'd0;
    remaining[SIG_UART_A_TX] = 1'b0;
    remaining[SIG_UART_A_RX] = 1'b0;
    for (int p = 0; p < XBAR_PINS; p++) begin
      pin_owned[p] = 1'b0;
      pin_slot[p]  = 5'd0;
      found        = 1'b0;
      pick         = 5'd0;
      if (xbar_en) begin
        if (req_vec[SIG_UART_A_TX] && p == `UART_A_TX_PIN) begin
          pin_owned[p] = 1'b1;
          pin_slot[p]  = SIG_UART_A_TX;
        end else if (req_vec[SIG_UART_A_RX] && p == `UART_A_RX_PIN) begin
          pin_owned[p] = 1'b1;
          pin_slot[p]  = SIG_UART_A_RX;
        end else if (!skip_mask[p]) begin
          for (int j = 0; j < NSIG; j++) begin
            if (!found && remaining[j]) begin
              found = 1'b1;
              pick  = 5'(j);
            end
          end
          if (found) begin
            remaining[pick] = 1'b0;
            pin_owned[p]    = 1'b1;
            pin_slot[p]     = pick;
          end
        end
      end
    end
  end

  // Pin drive, pullups and peripheral inputs
  always_comb begin
    per_in_next = '1;
    out_next    = '0;
    oe_n_next   = '1;
    for (int p = 0; p < XBAR_PINS; p++) begin
      if (!xbar_en) begin
        oe_n_next[p] = 1'b1;
      end else if (pin_owned[p]) begin
        out_next[p]  = per_out[pin_slot[p]];
        oe_n_next[p] = !per_drive[pin_slot[p]];
        per_in_next[pin_slot[p]] = pin_in[p];
      end else begin
        // GPIO cell is open-drain: a latch 1 leaves the pin as input
        oe_n_next[p] = latch_reg[p];
      end
    end
    // Separate loop keeps crossbar arrays indexed only in range
    for (int p = XBAR_PINS; p < ALL_PINS; p++) begin
      oe_n_next[p] = latch_reg[p];
    end
    for (int p = 0; p < ALL_PINS; p++) begin
      // Pullup is dropped while the pin is driven low to save power
      pull_next[p] = !route_b_reg[`B_PULLUP_DIS] && !(!oe_n_next[p] && !out_next[p]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out   <= '0;
      pin_oe_n  <= '1;
      pullup_en <= '1;
      per_in    <= '1;
    end else begin
      pin_out   <= out_next;
      pin_oe_n  <= oe_n_next;
      pullup_en <= pull_next;
      per_in    <= per_in_next;
    end
  end

endmodule

// >>> port_crossbar_routing_checker.sv
`timescale 1ns/10ps
module port_crossbar_routing_checker
  import port_crossbar_pkg::*;
#(
  parameter int NSIG      = 24,
  parameter int XBAR_PINS = 32,
  parameter int ALL_PINS  = 40
) (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire sfr_req_t             sfr_req,
  input wire logic                 spi_four_wire,
  input wire logic [XBAR_PINS-1:0] skip_mask,
  input wire logic [NSIG-1:0]      per_out,
  input wire logic [NSIG-1:0]      per_drive,
  input wire logic [ALL_PINS-1:0]  pin_in,
  input wire logic [7:0]           sfr_rdata,
  input wire logic [NSIG-1:0]      per_in,
  input wire logic [ALL_PINS-1:0]  pin_out,
  input wire logic [ALL_PINS-1:0]  pin_oe_n,
  input wire logic [ALL_PINS-1:0]  pullup_en
);
  logic xbar_reg;
  logic pud_reg;
  logic uart_reg;
  // Shadows of the enable bits, rebuilt from the write stream
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xbar_reg <= 1'b0;
      pud_reg  <= 1'b0;
    end else if (sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == 8'hE2) begin
      xbar_reg <= sfr_req.wdata[6];
      pud_reg  <= sfr_req.wdata[7];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uart_reg <= 1'b0;
    end else if (sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == 8'hE1) begin
      uart_reg <= sfr_req.wdata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_p0_rd;
    sfr_req.rd && !sfr_req.rmw && sfr_req.addr == 8'h80;
  endsequence
  sequence s_p4_rd;
    sfr_req.rd && !sfr_req.rmw && sfr_req.addr == 8'hC7;
  endsequence
  chk_rdata_idle: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00)
    else $error("read data not idle");
  chk_pin_read: assert property (s_p0_rd |=> sfr_rdata == $past(pin_in[7:0]))
    else $error("port read not pin level");
  chk_port4_read: assert property (s_p4_rd |=> sfr_rdata == $past(pin_in[39:32]))
    else $error("port four read wrong");
  chk_route_c_rd: assert property (sfr_req.rd && sfr_req.addr == 8'hE3
    |=> sfr_rdata[7:2] == 6'h00)
    else $error("reserved bits read set");
  chk_off_drivers: assert property (!xbar_reg |=> &pin_oe_n[31:0])
    else $error("driver on while crossbar off");
  chk_pullup_dis: assert property (pud_reg |=> pullup_en == '0)
    else $error("pullup on while disabled");
  chk_pullup_idle: assert property (!pud_reg && !xbar_reg |=> &pullup_en[31:0])
    else $error("pullup off while enabled");
  chk_uart_tx: assert property (uart_reg && xbar_reg && per_drive[0]
    |=> pin_out[4] == $past(per_out[0]))
    else $error("uart transmit pin wrong");
  chk_uart_rx: assert property (uart_reg && xbar_reg |=> per_in[1] == $past(pin_in[5]))
    else $error("uart receive pin wrong");
  chk_unrouted_inputs: assert property (!xbar_reg |=> per_in == '1)
    else $error("peripheral input routed while crossbar off");
  chk_nss_three_wire: assert property (!spi_four_wire |=> per_in[5])
    else $error("slave select routed in three wire mode");
  chk_skipped_pin: assert property (skip_mask[0] |=> !pin_out[0])
    else $error("skipped pin carries a peripheral");
endmodule

bind port_crossbar_routing port_crossbar_routing_checker #(
  .NSIG(NSIG), .XBAR_PINS(XBAR_PINS), .ALL_PINS(ALL_PINS)
) port_crossbar_routing_checker_i (
  .clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req), .spi_four_wire(spi_four_wire),
  .skip_mask(skip_mask), .per_out(per_out), .per_drive(per_drive), .pin_in(pin_in),
  .sfr_rdata(sfr_rdata), .per_in(per_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pullup_en(pullup_en)
);

// >>> tb.sv
`timescale 1ns/10ps
module tb
  import port_crossbar_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  sfr_req_t    req = '0;
  logic        sfo = 1'b0;
  logic [31:0] skip = '0;
  logic [23:0] pout = '0;
  logic [23:0] pdrv = '0;
  logic [39:0] pin = '0;
  logic [7:0]  rdata;
  logic [7:0]  got;
  logic [23:0] seen_in;
  logic [39:0] po;
  logic [39:0] poe;
  logic [39:0] pu;
  int          failures = 0;
  int          n_compared = 0;
  logic [15:0] rt [12] = '{16'hE180, 16'hE140, 16'hE120, 16'hE110, 16'hE108, 16'hE104,
                           16'hE102, 16'hE260, 16'hE250, 16'hE248, 16'hE302, 16'hE301};
  int          slot [12] = '{11, 10, 9, 8, 12, 6, 2, 19, 18, 17, 20, 22};
  int          ncex [8] = '{0, 1, 2, 3, 4, 4, 0, 0};

  port_crossbar_routing port_crossbar_routing_i (
    .clk(clk), .sys_rst(sys_rst), .sfr_req(req), .spi_four_wire(sfo), .skip_mask(skip),
    .per_out(pout), .per_drive(pdrv), .pin_in(pin), .sfr_rdata(rdata), .per_in(seen_in),
    .pin_out(po), .pin_oe_n(poe), .pullup_en(pu)
  );

  always #10 clk = ~clk;

  task stop_test;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input logic [39:0] s, input logic [39:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One idle cycle between requests keeps each req change in its own step
  task op(input logic w, r, m, b, input logic [2:0] s, input logic [7:0] a, v);
    @(negedge clk);
    req = '{w, r, m, b, s, a, v};
    @(negedge clk);
    got = rdata;
    req = '0;
  endtask

  task wr(input logic [7:0] a, v);
    op(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, a, v);
  endtask

  task rd(input logic [7:0] a, input logic m);
    op(1'b0, 1'b1, m, 1'b0, 3'h0, a, 8'h00);
  endtask

  task t_reset;
    rd(8'hE1, 1'b0); chk(got, 8'h00);
    rd(8'hE2, 1'b0); chk(got, 8'h00);
    rd(8'hE3, 1'b0); chk(got, 8'h00);
    rd(8'h80, 1'b1); chk(got, 8'hFF);
    wr(8'hE1, 8'hA5); rd(8'hE1, 1'b0); chk(got, 8'hA5);
    wr(8'hE2, 8'h9F); rd(8'hE2, 1'b0); chk(got, 8'h9F);
    wr(8'hE3, 8'h03); rd(8'hE3, 1'b0); chk(got, 8'h03);
    wr(8'h55, 8'hAA); rd(8'h55, 1'b0); chk(got, 8'h00);
    wr(8'hE2, 8'h00); wr(8'hE3, 8'h00); wr(8'hE1, 8'h01);
    pdrv[0] = 1'b1;
    cyc(2);
    chk(poe[31:0], 32'hFFFF_FFFF);
    chk(pu, 40'hFF_FFFF_FFFF);
  endtask

  task t_gpio;
    skip = '1;
    wr(8'hC7, 8'hF0);
    op(1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 8'hC7, 8'h01);
    wr(8'h90, 8'h5A);
    cyc(2);
    chk(poe[39:32], 8'hF0);
    chk(poe[15:8], 8'hFF);
    wr(8'hE2, 8'h40);
    op(1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 8'h90, 8'h01);
    cyc(2);
    chk(poe[15:8], 8'h5B);
    chk(pu[15:8], 8'h5B);
    rd(8'h90, 1'b1); chk(got, 8'h5B);
    pin[15:8] = 8'h3C;
    rd(8'h90, 1'b0); chk(got, 8'h3C);
    rd(8'hC7, 1'b1); chk(got, 8'hF0);
    wr(8'hE2, 8'hC0);
    cyc(2);
    chk(pu, 40'h00_0000_0000);
  endtask

  task t_uart;
    skip = '0;
    pin = '0;
    wr(8'hE2, 8'h40);
    pout[0] = 1'b1;
    cyc(2);
    chk(po[4], 1'b1);
    chk(seen_in[1], 1'b0);
    chk(poe[5:4], 2'h2);
    pout[0] = 1'b0;
    pin[5] = 1'b1;
    cyc(2);
    chk(po[4], 1'b0);
    chk(seen_in[1], 1'b1);
    rd(8'h80, 1'b0); chk(got, 8'h20);
    wr(8'hE1, 8'h00);
  endtask

  task t_route;
    pin = '0;
    for (int i = 0; i < 12; i++) begin
      wr(8'hE1, 8'h00); wr(8'hE3, 8'h00); wr(8'hE2, 8'h40);
      cyc(2);
      chk(seen_in[slot[i]], 1'b1);
      wr(rt[i][15:8], rt[i][7:0]);
      cyc(2);
      chk(seen_in[slot[i]], 1'b0);
    end
    sfo = 1'b1;
    wr(8'hE3, 8'h00); wr(8'hE1, 8'h02);
    cyc(2);
    chk(seen_in[5], 1'b0);
    pin[3:0] = 4'hA;
    cyc(2);
    chk(seen_in[5:2], 4'hA);
    skip[0] = 1'b1;
    cyc(2);
    chk(seen_in[5:2], 4'h5);
    skip = '0;
    pin = '0;
    sfo = 1'b0;
    cyc(2);
    chk(seen_in[5], 1'b1);
    wr(8'hE1, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'hE2, 8'h40 | 8'(c));
      cyc(2);
      for (int k = 0; k < 4; k++) chk(seen_in[13+k], k >= ncex[c]);
    end
  endtask

  initial begin
    #(20 * 20000);
    failures++;
    stop_test;
  end

  initial begin
    cyc(16);
    sys_rst = 1'b0;
    t_reset;
    t_gpio;
    wr(8'hE1, 8'h01);
    t_uart;
    t_route;
    stop_test;
  end
endmodule
